// *** spr_pkg.sv ***
// constants and types for the stack, power-save and repeat execution block
// assumes a 16-bit core with a 23-bit program counter
package spr_pkg;
   localparam logic [7:0]  ADDR_SP         = 8'h00;
   localparam logic [7:0]  ADDR_RCR        = 8'h04;
   localparam logic [7:0]  ADDR_REP        = 8'h08;
   localparam logic [7:0]  ADDR_IRQ_STATUS = 8'h0c;
   localparam logic [7:0]  ADDR_IRQ_MASK   = 8'h10;
   localparam int          WATCHDOG_TIMEOUT_FLAG_BIT        = 4;
   localparam int          SLEEP_BIT       = 3;
   localparam int          IDLE_BIT        = 2;
   localparam int          RA_BIT          = 14;
   localparam int          REP_BITS        = 14;
   localparam logic [15:0] SP_RESET        = 16'h0800;
   localparam logic [15:0] STACK_STEP      = 16'h0002;
   localparam logic [22:0] PC_STEP         = 23'h000002;
   localparam int          EV_SAVE         = 0;
   localparam int          EV_WAKE         = 1;
   localparam int          EV_REP_DONE     = 2;
   localparam int          EV_W            = 3;

   typedef enum logic [3:0] {OP_NONE, OP_PUSH, OP_PUSH_D, OP_PUSH_S, OP_POP_S,
                             OP_POWER_SAVE_INSTR, OP_RELATIVE_CALL_INSTR, OP_REPEAT_LIT, OP_REPEAT_REG} op_t;
   typedef enum logic [1:0] {PW_RUN, PW_SLEEP, PW_IDLE} pwr_t;
   typedef enum logic [1:0] {SQ_IDLE, SQ_HI, SQ_CALL} seq_t;

   typedef struct packed {
      op_t         op;
      logic [15:0] src_lo;
      logic [15:0] src_hi;
      logic [15:0] count_src;
      logic        power_mode_select;
      logic [15:0] offset;
      logic [22:0] pc;
   } instr_t;

   typedef struct packed {
      logic [15:0] w0;
      logic [15:0] w1;
      logic [15:0] w2;
      logic [15:0] w3;
      logic [4:0]  sr_bits;
   } shadow_t;

   typedef struct packed {
      logic        we;
      logic [15:0] addr;
      logic [15:0] wdata;
   } mem_wr_t;

   typedef struct packed {
      logic cpu;
      logic periph;
      logic osc;
   } clk_en_t;

   typedef struct packed {
      seq_t                      seq;
      pwr_t                      pwr;
      logic [15:0]               sp;
      logic [15:0]               hi_word;
      logic [22:0]               pc_next;
      logic                      pc_load;
      logic [REP_BITS-1:0]       repeat_counter;
      logic                      repeat_active_flag;
      logic [WATCHDOG_TIMEOUT_FLAG_BIT:IDLE_BIT]  rcr_flags;
      logic                      wdt_clear;
      shadow_t                   shadow;
      logic                      restore;
      mem_wr_t                   mem;
      logic [EV_W-1:0]           irq_status;
      logic [EV_W-1:0]           irq_mask;
      logic [15:0]               rdata;
   } state_t;
endpackage

// *** stack_powersave_repeat_exec.sv ***
// executes stack pushes, shadow push/restore, power save, relative call and repeat loops
// assumes the decode stage, register file and clock gates share clk; all inputs except the asynchronous reset arst_n are synchronous
// Function
// RULE1: shadow restore leaves shadow contents unchanged
// RULE2: power save clears watchdog and three flags
// RULE3: mode 0 enters sleep, all clocks stop
// RULE4: mode 1 enters idle, only cpu stops
// RULE5: wake on interrupt, reset or watchdog timeout
// RULE6: idle wake sets idle flag, cpu clock
// RULE7: sleep wake sets sleep flag, restarts oscillator
// RULE8: watchdog wake sets timeout flag
// RULE9: register repeat loads low 14 bits only
// RULE10: target runs count plus one times
// RULE11: target fetched once, held in register
// RULE12: counter decrements after each target execution
// RULE13: at zero, one final run then continue
// RULE14: register repeat of zero is no-op
// RULE15: software avoids illegal repeat targets
// RULE16: interrupts allowed during repeat and target
// RULE17: push writes at pointer, pointer plus two
// RULE18: relative call pushes pc+2, adds offset
// RULE19: nonzero repeat sets flag, completion clears
//
// Implementation choices: strobed register access and the address map.
module stack_powersave_repeat_exec
   import spr_pkg::*;
#(
   parameter logic [15:0] STACK_BASE = SP_RESET
)(
   // clock and reset
   input  wire logic    clk,
   input  wire logic    arst_n,
   // decode stage
   input  wire logic    instr_valid,
   input  instr_t       instr,
   output logic         instr_ready,
   input  wire logic    target_done,
   output logic         hold_ir,
   output logic         int_allow,
   // primary registers and shadow restore
   input  shadow_t      primary,
   output shadow_t      restore_data,
   output logic         restore_load,
   // data memory write and program counter
   output mem_wr_t      mem,
   output logic         pc_load,
   output logic [22:0]  pc_next,
   // power control
   input  wire logic    wake_irq,
   input  wire logic    wake_reset,
   input  wire logic    wdt_timeout,
   output logic         wdt_clear,
   output clk_en_t      clk_en,
   output logic [15:0]  reset_control_register,
   // register port
   input  wire logic [7:0]  addr,
   input  wire logic [15:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic [15:0]  rdata,
   output logic         irq
);

   if (STACK_BASE[0] != 1'b0) begin : g_chk
      $error("stack base must be word aligned");
   end

   state_t s;
   state_t next_s;

   logic acc;
   logic wake;
   logic [EV_W-1:0] ev;
   logic [REP_BITS-1:0] cnt;
   logic [22:0] ret_pc;

   function automatic mem_wr_t stack_write(input logic [15:0] a, input logic [15:0] d);
      mem_wr_t m;
      m.we = 1'b1;
      m.addr = a;
      m.wdata = d;
      return m;
   endfunction

   assign acc = instr_valid && instr_ready;
   assign wake = wake_irq || wake_reset || wdt_timeout;
   assign ret_pc = instr.pc + PC_STEP;

   always_comb begin
      next_s = s;
      ev = '0;
      cnt = instr.count_src[REP_BITS-1:0];
      next_s.mem = '0;
      next_s.pc_load = 1'b0;
      next_s.wdt_clear = 1'b0;
      next_s.restore = 1'b0;
      next_s.rdata = 16'h0000;
      // software writes first so hardware sets win in the same cycle
      if (wr) begin
         case (addr)
            ADDR_SP: next_s.sp = {wdata[15:1], 1'b0};
            ADDR_RCR: next_s.rcr_flags = wdata[WATCHDOG_TIMEOUT_FLAG_BIT:IDLE_BIT];
            ADDR_IRQ_STATUS: next_s.irq_status = s.irq_status & ~wdata[EV_W-1:0];
            ADDR_IRQ_MASK: next_s.irq_mask = wdata[EV_W-1:0];
            default: ;
         endcase
      end
      if (rd) begin
         case (addr)
            ADDR_SP: next_s.rdata = s.sp;
            ADDR_RCR: next_s.rdata = {11'h000, s.rcr_flags, 2'h0};
            ADDR_REP: next_s.rdata = {1'b0, s.repeat_active_flag, s.repeat_counter};
            ADDR_IRQ_STATUS: next_s.rdata = {13'h0000, s.irq_status};
            ADDR_IRQ_MASK: next_s.rdata = {13'h0000, s.irq_mask};
            default: next_s.rdata = 16'h0000;
         endcase
      end
      // second stack word of a double push or call
      case (s.seq)
         SQ_HI, SQ_CALL: begin
            next_s.mem = stack_write(s.sp, s.hi_word); // RULE17
            next_s.sp = s.sp + STACK_STEP; // RULE17
            next_s.pc_load = (s.seq == SQ_CALL); // RULE18
            next_s.seq = SQ_IDLE;
         end
         default: ;
      endcase
      if (acc) begin
         case (instr.op)
            OP_PUSH: begin
               next_s.mem = stack_write(s.sp, instr.src_lo); // RULE17
               next_s.sp = s.sp + STACK_STEP; // RULE17
            end
            OP_PUSH_D: begin
               next_s.mem = stack_write(s.sp, instr.src_lo); // RULE17
               next_s.sp = s.sp + STACK_STEP;
               next_s.hi_word = instr.src_hi;
               next_s.seq = SQ_HI;
            end
            OP_RELATIVE_CALL_INSTR: begin
               next_s.mem = stack_write(s.sp, ret_pc[15:0]); // RULE18
               next_s.sp = s.sp + STACK_STEP;
               next_s.hi_word = {9'h000, ret_pc[22:16]};
               next_s.pc_next = ret_pc + {{6{instr.offset[15]}}, instr.offset, 1'b0}; // RULE18
               next_s.seq = SQ_CALL;
            end
            OP_PUSH_S: next_s.shadow = primary;
            OP_POP_S: next_s.restore = 1'b1; // RULE1
            OP_POWER_SAVE_INSTR: begin
               next_s.wdt_clear = 1'b1; // RULE2
               next_s.rcr_flags = '0; // RULE2
               next_s.pwr = instr.power_mode_select ? PW_IDLE : PW_SLEEP; // RULE3 RULE4
               ev[EV_SAVE] = 1'b1;
            end
            OP_REPEAT_LIT, OP_REPEAT_REG: begin
               next_s.repeat_counter = cnt; // RULE9
               next_s.repeat_active_flag = (cnt != '0); // RULE14 RULE19
            end
            default: ;
         endcase
      end
      // each execution of the held target counts down the loop
      if (s.repeat_active_flag && target_done) begin
         if (s.repeat_counter == '0) begin
            next_s.repeat_active_flag = 1'b0; // RULE13 RULE19
            ev[EV_REP_DONE] = 1'b1;
         end else begin
            next_s.repeat_counter = s.repeat_counter - 1'b1; // RULE12 RULE10
         end
      end
      if (s.pwr != PW_RUN && wake) begin
         next_s.pwr = PW_RUN; // RULE5
         if (s.pwr == PW_IDLE) begin
            next_s.rcr_flags[IDLE_BIT] = 1'b1; // RULE6
         end else begin
            next_s.rcr_flags[SLEEP_BIT] = 1'b1; // RULE7
         end
         if (wdt_timeout) begin
            next_s.rcr_flags[WATCHDOG_TIMEOUT_FLAG_BIT] = 1'b1; // RULE8
         end
         ev[EV_WAKE] = 1'b1;
      end
      next_s.irq_status = next_s.irq_status | ev;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s <= '0;
         s.sp <= STACK_BASE;
         s.seq <= SQ_IDLE;
         s.pwr <= PW_RUN;
      end else begin
         s <= next_s;
      end
   end

   // new work waits for the second stack word and for the clock to return
   assign instr_ready = (s.seq == SQ_IDLE) && (s.pwr == PW_RUN);
   assign hold_ir = s.repeat_active_flag; // RULE11
   assign int_allow = (s.seq == SQ_IDLE); // RULE16
   assign restore_data = s.shadow;
   assign restore_load = s.restore;
   assign mem = s.mem;
   assign pc_load = s.pc_load;
   assign pc_next = s.pc_next;
   assign wdt_clear = s.wdt_clear;
   assign clk_en.cpu = (s.pwr == PW_RUN); // RULE3 RULE4
   assign clk_en.periph = (s.pwr != PW_SLEEP); // RULE3 RULE4
   assign clk_en.osc = (s.pwr != PW_SLEEP); // RULE3 RULE7
   assign reset_control_register = {11'h000, s.rcr_flags, 2'h0};
   assign rdata = s.rdata;
   assign irq = |(s.irq_status & s.irq_mask);

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);

   shadow_keep_a: assert property ( // RULE1
      acc && instr.op == OP_POP_S |=> restore_load && restore_data == $past(s.shadow))
      else $error("shadow changed by restore");

   save_clear_a: assert property ( // RULE2
      acc && instr.op == OP_POWER_SAVE_INSTR |=> wdt_clear && reset_control_register == 16'h0000)
      else $error("power save did not clear watchdog and flags");

   sleep_enter_a: assert property ( // RULE3
      acc && instr.op == OP_POWER_SAVE_INSTR && !instr.power_mode_select |=> clk_en == 3'b000)
      else $error("sleep left a clock running");

   idle_enter_a: assert property ( // RULE4
      acc && instr.op == OP_POWER_SAVE_INSTR && instr.power_mode_select |=> clk_en == 3'b011)
      else $error("idle clocks wrong");

   wake_exit_a: assert property ( // RULE5
      s.pwr != PW_RUN && wake |=> clk_en.cpu && instr_ready)
      else $error("no wake on wake source");

   idle_flag_a: assert property ( // RULE6
      s.pwr == PW_IDLE && wake |=> reset_control_register[IDLE_BIT] && clk_en.cpu)
      else $error("idle wake flag missing");

   sleep_flag_a: assert property ( // RULE7
      s.pwr == PW_SLEEP && wake |=> reset_control_register[SLEEP_BIT] && clk_en.osc)
      else $error("sleep wake flag missing");

   watchdog_timeout_flag_flag_a: assert property ( // RULE8
      s.pwr != PW_RUN && wdt_timeout |=> reset_control_register[WATCHDOG_TIMEOUT_FLAG_BIT])
      else $error("watchdog wake flag missing");

   rep_load_a: assert property ( // RULE9
      acc && instr.op == OP_REPEAT_REG |=> s.repeat_counter == $past(instr.count_src[13:0]))
      else $error("repeat count load wrong");

   rep_zero_a: assert property ( // RULE14
      acc && instr.op == OP_REPEAT_REG && instr.count_src[13:0] == 14'h0000 |=> !hold_ir)
      else $error("zero repeat set active flag");

   rep_dec_a: assert property ( // RULE12
      hold_ir && target_done && s.repeat_counter != '0
      |=> hold_ir && s.repeat_counter == $past(s.repeat_counter) - 1'b1)
      else $error("repeat counter did not decrement");

   rep_end_a: assert property ( // RULE13
      hold_ir && target_done && s.repeat_counter == '0 |=> !hold_ir)
      else $error("repeat did not finish at zero");

   push_word_a: assert property ( // RULE17
      acc && instr.op == OP_PUSH
      |=> mem.we && mem.addr == $past(s.sp) && s.sp == $past(s.sp) + STACK_STEP)
      else $error("push address or pointer wrong");

   relative_call_instr_pc_a: assert property ( // RULE18
      acc && instr.op == OP_RELATIVE_CALL_INSTR |=> mem.we && !pc_load ##1 mem.we && pc_load)
      else $error("relative call sequence wrong");

   // repeat loop
   rep_count_a: assert property ( // RULE10
      hold_ir && target_done && s.repeat_counter != '0 |=> hold_ir)
      else $error("repeat ended before count plus one runs");

   ir_hold_a: assert property ( // RULE11
      acc && instr.op == OP_REPEAT_LIT && instr.count_src[13:0] != 14'h0000 |=> hold_ir)
      else $error("instruction register not held");

   int_rep_a: assert property ( // RULE16
      hold_ir && s.seq == SQ_IDLE |-> int_allow)
      else $error("interrupts blocked during repeat");

   ra_set_a: assert property ( // RULE19
      acc && instr.op == OP_REPEAT_REG && instr.count_src[13:0] != 14'h0000 |=> hold_ir)
      else $error("repeat active flag not set");

   ra_clear_a: assert property ( // RULE19
      hold_ir && target_done && s.repeat_counter == '0 |=> !hold_ir && s.irq_status[EV_REP_DONE])
      else $error("repeat active flag not cleared");

   lit_load_a: assert property ( // RULE10
      acc && instr.op == OP_REPEAT_LIT |=> s.repeat_counter == $past(instr.count_src[13:0]))
      else $error("literal repeat count load wrong");

   lit_zero_a: assert property ( // RULE14
      acc && instr.op == OP_REPEAT_LIT && instr.count_src[13:0] == 14'h0000 |=> !hold_ir)
      else $error("zero literal repeat set active flag");

   // stack and call
   pushd_lo_a: assert property ( // RULE17
      acc && instr.op == OP_PUSH_D |=> mem.we && mem.wdata == $past(instr.src_lo) && !instr_ready)
      else $error("double push low word wrong");

   pushd_hi_a: assert property ( // RULE17
      acc && instr.op == OP_PUSH_D |=> ##1 mem.we && mem.wdata == $past(instr.src_hi, 2))
      else $error("double push high word wrong");

   pushd_sp_a: assert property ( // RULE17
      acc && instr.op == OP_PUSH_D |=> ##1 s.sp == $past(s.sp, 2) + STACK_STEP + STACK_STEP)
      else $error("double push pointer wrong");

   sp_align_a: assert property ( // RULE17
      !s.sp[0])
      else $error("stack pointer odd");

   relative_call_instr_ret_a: assert property ( // RULE18
      acc && instr.op == OP_RELATIVE_CALL_INSTR |=> mem.wdata == $past(ret_pc[15:0]) && mem.addr == $past(s.sp))
      else $error("relative call return word wrong");

   relative_call_instr_hi_a: assert property ( // RULE18
      acc && instr.op == OP_RELATIVE_CALL_INSTR |=> ##1 mem.wdata[15:7] == 9'h000)
      else $error("relative call high word wrong");

   relative_call_instr_wait_a: assert property ( // RULE18
      acc && instr.op == OP_RELATIVE_CALL_INSTR |=> !instr_ready && !int_allow)
      else $error("relative call second word not guarded");

   // shadow registers
   shadow_load_a: assert property ( // RULE1
      acc && instr.op == OP_PUSH_S |=> restore_data == $past(primary))
      else $error("shadow push wrong");

   restore_stable_a: assert property ( // RULE1
      restore_load |-> $stable(restore_data))
      else $error("shadow moved during restore");

   // power control
   wdt_pulse_a: assert property ( // RULE2
      wdt_clear |=> !wdt_clear)
      else $error("watchdog clear not a pulse");

   save_ev_a: assert property ( // RULE2
      acc && instr.op == OP_POWER_SAVE_INSTR |=> s.irq_status[EV_SAVE])
      else $error("power save event missing");

   sleep_stay_a: assert property ( // RULE3
      s.pwr == PW_SLEEP && !wake |=> clk_en == 3'b000 && !instr_ready)
      else $error("sleep left early");

   sleep_osc_a: assert property ( // RULE3
      s.pwr == PW_SLEEP |-> !clk_en.osc && !clk_en.periph)
      else $error("oscillator running in sleep");

   idle_stay_a: assert property ( // RULE4
      s.pwr == PW_IDLE && !wake |=> clk_en == 3'b011)
      else $error("idle left early");

   idle_osc_a: assert property ( // RULE4
      s.pwr == PW_IDLE |-> clk_en.osc && clk_en.periph && !clk_en.cpu)
      else $error("idle clock split wrong");

   run_clk_a: assert property ( // RULE5
      s.pwr == PW_RUN |-> clk_en == 3'b111)
      else $error("clock stopped while running");

   wake_ev_a: assert property ( // RULE5
      s.pwr != PW_RUN && wake |=> s.irq_status[EV_WAKE])
      else $error("wake event missing");

   sleep_wake_c: cover property (s.pwr == PW_SLEEP && wake);
   idle_wake_c: cover property (s.pwr == PW_IDLE && wake);
   rep_done_c: cover property (hold_ir && target_done && s.repeat_counter == '0);
   relative_call_instr_c: cover property (pc_load);
   push_d_c: cover property (s.seq == SQ_HI);

endmodule

// *** tb.sv ***
// self-checking bench for the stack, power-save and repeat execution block
// assumes the default stack base; the bench drives every port directly at the rising edge
module tb
   import spr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   logic        clk;
   logic        arst_n;
   logic        instr_valid;
   instr_t      instr;
   logic        instr_ready;
   logic        target_done;
   logic        hold_ir;
   logic        int_allow;
   shadow_t     primary;
   shadow_t     restore_data;
   logic        restore_load;
   mem_wr_t     mem;
   logic        pc_load;
   logic [22:0] pc_next;
   logic        wake_irq;
   logic        wake_reset;
   logic        wdt_timeout;
   logic        wdt_clear;
   clk_en_t     clk_en;
   logic [15:0] reset_control_register;
   logic [7:0]  addr;
   logic [15:0] wdata;
   logic        wr;
   logic        rd;
   logic [15:0] rdata;
   logic        irq;
   logic [15:0] v;
   shadow_t     sh;
   int          failures;
   int          tests_run;

   stack_powersave_repeat_exec stack_powersave_repeat_exec_i (
      .clk(clk), .arst_n(arst_n), .instr_valid(instr_valid), .instr(instr),
      .instr_ready(instr_ready), .target_done(target_done), .hold_ir(hold_ir),
      .int_allow(int_allow), .primary(primary), .restore_data(restore_data),
      .restore_load(restore_load), .mem(mem), .pc_load(pc_load), .pc_next(pc_next),
      .wake_irq(wake_irq), .wake_reset(wake_reset), .wdt_timeout(wdt_timeout),
      .wdt_clear(wdt_clear), .clk_en(clk_en), .reset_control_register(reset_control_register),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic chk(input logic [71:0] got, input logic [71:0] exp);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic conclude;
      if (failures == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic tick;
      @(posedge clk);
      #1;
   endtask

   task automatic wreg(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask

   task automatic rreg(input logic [7:0] a, output logic [15:0] d);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask

   // one instruction; returns one step after the accepting edge
   task automatic issue(input op_t o, input logic [15:0] lo, input logic [15:0] hi, input logic [22:0] p);
      @(posedge clk);
      instr_valid <= 1'b1;
      instr <= '{op: o, src_lo: lo, src_hi: hi, count_src: lo, power_mode_select: lo[0], offset: hi, pc: p};
      @(posedge clk);
      instr_valid <= 1'b0;
      #1;
   endtask

   task automatic t_stack;
      issue(OP_PUSH, 16'h6889, 16'h0000, 23'h0);
      chk(mem, {1'b1, 16'h0800, 16'h6889});
      issue(OP_PUSH_D, 16'hc451, 16'h3380, 23'h0);
      chk(mem, {1'b1, 16'h0802, 16'hc451});
      tick;
      chk(mem, {1'b1, 16'h0804, 16'h3380});
      issue(OP_RELATIVE_CALL_INSTR, 16'h0000, 16'h0229, 23'h012004);
      chk(mem, {1'b1, 16'h0806, 16'h2006});
      tick;
      chk(mem, {1'b1, 16'h0808, 16'h0001});
      chk({pc_load, pc_next}, {1'b1, 23'h012458});
      issue(OP_RELATIVE_CALL_INSTR, 16'h0000, 16'hfffe, 23'h000100);
      tick;
      chk({pc_load, pc_next}, {1'b1, 23'h0000fe});
      rreg(ADDR_SP, v);
      chk(v, 16'h080e);
   endtask

   task automatic t_repeat;
      issue(OP_REPEAT_REG, 16'hc005, 16'h0000, 23'h0);
      rreg(ADDR_REP, v);
      chk(v, 16'h4005);
      for (int i = 0; i < 6; i++) begin
         chk(hold_ir, 1'b1);
         @(posedge clk);
         target_done <= 1'b1;
         @(posedge clk);
         target_done <= 1'b0;
         #1 chk(int_allow, 1'b1);
         if (i == 0) begin
            rreg(ADDR_REP, v);
            chk(v, 16'h4004);
         end
      end
      chk(hold_ir, 1'b0);
      rreg(ADDR_REP, v);
      chk(v, 16'h0000);
      issue(OP_REPEAT_REG, 16'h0000, 16'h0000, 23'h0);
      chk(hold_ir, 1'b0);
      rreg(ADDR_REP, v);
      chk(v, 16'h0000);
   endtask

   task automatic t_power;
      wreg(ADDR_RCR, 16'h001c);
      issue(OP_POWER_SAVE_INSTR, 16'h0000, 16'h0000, 23'h0);
      chk({wdt_clear, reset_control_register}, {1'b1, 16'h0000});
      chk(clk_en, 3'b000);
      @(posedge clk);
      wake_irq <= 1'b1;
      @(posedge clk);
      wake_irq <= 1'b0;
      #1 chk({clk_en, reset_control_register}, {3'b111, 16'h0008});
      issue(OP_POWER_SAVE_INSTR, 16'h0001, 16'h0000, 23'h0);
      chk({clk_en, reset_control_register}, {3'b011, 16'h0000});
      @(posedge clk);
      wdt_timeout <= 1'b1;
      @(posedge clk);
      wdt_timeout <= 1'b0;
      #1 chk({clk_en, reset_control_register}, {3'b111, 16'h0014});
      issue(OP_POWER_SAVE_INSTR, 16'h0001, 16'h0000, 23'h0);
      @(posedge clk);
      wake_reset <= 1'b1;
      @(posedge clk);
      wake_reset <= 1'b0;
      #1 chk({clk_en, reset_control_register}, {3'b111, 16'h0004});
   endtask

   task automatic t_shadow;
      sh = {16'h0000, 16'h1000, 16'h2000, 16'h3000, 5'h01};
      @(posedge clk);
      primary <= sh;
      issue(OP_PUSH_S, 16'h0000, 16'h0000, 23'h0);
      chk(restore_data, sh);
      @(posedge clk);
      primary <= ~sh;
      issue(OP_POP_S, 16'h0000, 16'h0000, 23'h0);
      chk({restore_load, restore_data}, {1'b1, sh});
   endtask

   task automatic t_irq;
      rreg(ADDR_IRQ_STATUS, v);
      chk({irq, v}, {1'b0, 16'h0007});
      wreg(ADDR_IRQ_MASK, 16'h0004);
      rreg(8'h14, v);
      chk({irq, v}, {1'b1, 16'h0000});
      wreg(ADDR_IRQ_STATUS, 16'h0004);
      rreg(ADDR_IRQ_STATUS, v);
      chk({irq, v}, {1'b0, 16'h0003});
   endtask

   initial begin
      #2_000_000;
      failures++;
      conclude;
   end

   initial begin
      failures = 0;
      tests_run = 0;
      arst_n = 1'b0;
      instr_valid = 1'b0;
      instr = '0;
      target_done = 1'b0;
      primary = '0;
      wake_irq = 1'b0;
      wake_reset = 1'b0;
      wdt_timeout = 1'b0;
      addr = 8'h00;
      wdata = 16'h0000;
      wr = 1'b0;
      rd = 1'b0;
      repeat (20) @(posedge clk);
      chk({clk_en, instr_ready, irq}, {3'b111, 1'b1, 1'b0});
      arst_n <= 1'b1;
      t_stack;
      t_repeat;
      t_power;
      t_shadow;
      t_irq;
      conclude;
   end
endmodule
